// ### rtl/port_pin_irq_pkg.sv
// Package: register map, field positions, reset values and carrier structs
package port_pin_irq_pkg;
  // ****************************************************
  // Register byte addresses
  // ****************************************************
  localparam logic [11:0] ADDR_PORT_T_DATA = 12'h240;
  localparam logic [11:0] ADDR_PORT_T_INPUT = 12'h244;
  localparam logic [11:0] ADDR_PORT_T_DIR = 12'h248;
  localparam logic [11:0] ADDR_MISC_CONFIG = 12'h250;
  localparam logic [11:0] ADDR_EXT_IRQ_CONTROL = 12'h254;
  localparam logic [11:0] ADDR_FACTORY_RESERVED = 12'h258;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h25C;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h260;
  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int OVERCURRENT_DETECT_ENABLE_BIT = 7;
  localparam int EDGE_ONLY_SELECT_BIT = 7;
  localparam int EXT_IRQ_CONNECT_BIT = 6;
  localparam int STAT_EXT_IRQ_BIT = 0;
  localparam int STAT_PIN_CHANGE_BIT = 1;
  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [7:0] RST_PORT_T_DATA = 8'h00;
  localparam logic [7:0] RST_PORT_T_DIR = 8'h00;
  localparam logic [7:0] RST_MISC_CONFIG = 8'h00;
  localparam logic [7:0] RST_EXT_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] RST_FACTORY_RESERVED = 8'h00;
  localparam logic [1:0] RST_IRQ_STATUS = 2'h0;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;
  localparam int PORT_T_WIDTH = 4;
  // ****************************************************
  // Carriers
  // ****************************************************
  // Per-pin peripheral requests for port T
  typedef struct packed {
    logic [3:0] spi_en;
    logic [3:0] spi_oe;
    logic [3:0] spi_out;
    logic [3:0] lin_en;
    logic [3:0] lin_oe;
    logic [3:0] lin_out;
    logic [3:0] uart0_en;
    logic [3:0] uart0_oe;
    logic [3:0] uart0_out;
    logic [3:0] lin_direct_drive_en;
    logic [3:0] lin_direct_drive_out;
    logic [3:0] timer_oc_en;
    logic [3:0] timer_oc_out;
    logic [3:0] pwm_en;
    logic [3:0] pwm_out;
    logic [3:0] high_side_driver_routed;
    logic [3:0] low_side_driver_routed;
    logic [3:0] lin_receive_out_used;
  } port_t_periph_s;
  // Pin-side drive of port T
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } port_t_drive_s;
endpackage

// ### rtl/port_pin_irq_control.sv
// Port T data path, external interrupt pin control and misc configuration
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - misc bit 7 enables overcurrent detector
// - edge select one: falling edges only
// - edge select zero: low level recognised
// - edge latch held until reset, service or edge select cleared
// - edge select write-once normal, connect anytime
// - connect bit 6 links pin to interrupts
// - factory registers writable only in special mode
// - data read: register if output, else pin
// - GPIO output drives stored data bit
// - bits 3-2: SPI over LIN over timer over GPIO
// - bit 1: uart0/LIN direct over timer over GPIO
// - bit 0: uart0 over timer over GPIO
// - PWM only when no driver routed
// - timer compare only when no driver routed
// - timer capture only without LIN receive
// - input register always returns synchronised pin
module port_pin_irq_control #(
  parameter int WIDTH = port_pin_irq_pkg::PORT_T_WIDTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode,
  input wire logic ext_irq_pin,
  input wire logic ext_irq_service,
  input wire logic [3:0] port_t_in,
  input wire port_pin_irq_pkg::port_t_periph_s periph,
  output port_pin_irq_pkg::port_t_drive_s port_t_drive,
  output logic [3:0] timer_capture_in,
  output logic [3:0] timer_capture_valid,
  output logic overcurrent_detect_enable,
  output logic ext_irq_req,
  output logic irq
);
  // Per-pin peripheral carriers are four bits wide, so no other width is served
  if (WIDTH != 4) begin : g_width_check
    $error("port_pin_irq_control supports only WIDTH of 4");
  end

  // ****************************************************
  // State
  // ****************************************************
  logic [7:0] port_t_data_ff, nxt_port_t_data;
  logic [7:0] port_t_dir_ff, nxt_port_t_dir;
  logic [7:0] misc_config_ff, nxt_misc_config;
  logic edge_only_select_ff, nxt_edge_only_select;
  logic edge_locked_ff, nxt_edge_locked;
  logic ext_irq_connect_ff, nxt_ext_irq_connect;
  logic [7:0] factory_reserved_ff, nxt_factory_reserved;
  logic [1:0] irq_status_ff, nxt_irq_status;
  logic [1:0] irq_mask_ff, nxt_irq_mask;
  logic [3:0] pin_sync, pin_prev;
  logic irq_meta_ff, irq_sync_ff, irq_prev_ff;
  logic edge_latch_ff, nxt_edge_latch;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic ext_irq_req_ff, nxt_ext_irq_req;
  logic irq_ff, nxt_irq;

  logic wr_en, rd_en, hit;
  logic [3:0] data_rd;
  logic irq_fall;
  logic [7:0] ctl_rd;

  assign wr_en = psel && penable && pwrite && !pready_ff;
  assign rd_en = psel && penable && !pwrite && !pready_ff;

  // ****************************************************
  // Synchronisers
  // ****************************************************
  // Flops reset to the idle high level, so release makes no false fall
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_meta_ff <= 1'b1;
      irq_sync_ff <= 1'b1;
      irq_prev_ff <= 1'b1;
    end else begin
      irq_meta_ff <= ext_irq_pin;
      irq_sync_ff <= irq_meta_ff;
      irq_prev_ff <= irq_sync_ff;
    end
  end

  assign irq_fall = irq_prev_ff && !irq_sync_ff;
  // Read direction picks register bit or synchronised pin
  assign data_rd = (port_t_dir_ff[3:0] & port_t_data_ff[3:0])
                 | (~port_t_dir_ff[3:0] & pin_sync);
  assign ctl_rd = {edge_only_select_ff, ext_irq_connect_ff, 6'h00};

  // ****************************************************
  // Register file and APB
  // ****************************************************
  always_comb begin
    nxt_port_t_data = port_t_data_ff;
    nxt_port_t_dir = port_t_dir_ff;
    nxt_misc_config = misc_config_ff;
    nxt_edge_only_select = edge_only_select_ff;
    nxt_edge_locked = edge_locked_ff;
    nxt_ext_irq_connect = ext_irq_connect_ff;
    nxt_factory_reserved = factory_reserved_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_prdata = 32'h0000_0000;
    nxt_pready = psel && penable && !pready_ff;
    nxt_pslverr = 1'b0;
    hit = 1'b1;
    case (paddr)
      port_pin_irq_pkg::ADDR_PORT_T_DATA: nxt_prdata = {28'h0000000, data_rd};
      port_pin_irq_pkg::ADDR_PORT_T_INPUT: nxt_prdata = {28'h0000000, pin_sync};
      port_pin_irq_pkg::ADDR_PORT_T_DIR: nxt_prdata = {28'h0000000, port_t_dir_ff[3:0]};
      port_pin_irq_pkg::ADDR_MISC_CONFIG: nxt_prdata = {24'h000000, misc_config_ff};
      port_pin_irq_pkg::ADDR_EXT_IRQ_CONTROL: nxt_prdata = {24'h000000, ctl_rd};
      port_pin_irq_pkg::ADDR_FACTORY_RESERVED: nxt_prdata = {24'h000000, factory_reserved_ff};
      port_pin_irq_pkg::ADDR_IRQ_STATUS: nxt_prdata = {30'h00000000, irq_status_ff};
      port_pin_irq_pkg::ADDR_IRQ_MASK: nxt_prdata = {30'h00000000, irq_mask_ff};
      default: hit = 1'b0;
    endcase
    if (!rd_en) begin
      nxt_prdata = prdata_ff;
    end
    if ((rd_en || wr_en) && !hit) begin
      nxt_pslverr = 1'b1;
    end
    if (wr_en) begin
      case (paddr)
        port_pin_irq_pkg::ADDR_PORT_T_DATA: nxt_port_t_data = {4'h0, pwdata[3:0]};
        port_pin_irq_pkg::ADDR_PORT_T_DIR: nxt_port_t_dir = {4'h0, pwdata[3:0]};
        port_pin_irq_pkg::ADDR_MISC_CONFIG: begin
          nxt_misc_config = {pwdata[7], 7'h00};
        end
        port_pin_irq_pkg::ADDR_EXT_IRQ_CONTROL: begin
          nxt_ext_irq_connect = pwdata[port_pin_irq_pkg::EXT_IRQ_CONNECT_BIT];
          if (special_mode || !edge_locked_ff) begin
            nxt_edge_only_select = pwdata[port_pin_irq_pkg::EDGE_ONLY_SELECT_BIT];
            // Special-mode writes neither set nor clear the lock
            nxt_edge_locked = edge_locked_ff || !special_mode;
          end
        end
        port_pin_irq_pkg::ADDR_FACTORY_RESERVED: begin
          if (special_mode) begin
            nxt_factory_reserved = pwdata[7:0];
          end
        end
        port_pin_irq_pkg::ADDR_IRQ_MASK: nxt_irq_mask = pwdata[1:0];
        default: nxt_irq_mask = irq_mask_ff;
      endcase
    end
  end

  // ****************************************************
  // Interrupt pin and status
  // ****************************************************
  always_comb begin
    logic [1:0] clr;
    logic [1:0] set;
    clr = 2'h0;
    set = 2'h0;
    nxt_edge_latch = edge_latch_ff;
    if (!edge_only_select_ff || ext_irq_service) begin
      nxt_edge_latch = 1'b0;
    end
    if (edge_only_select_ff && irq_fall) begin
      nxt_edge_latch = 1'b1;
    end
    // Connect gates the pin into the interrupt logic
    if (!ext_irq_connect_ff) begin
      nxt_ext_irq_req = 1'b0;
    end else if (edge_only_select_ff) begin
      nxt_ext_irq_req = nxt_edge_latch;
    end else begin
      nxt_ext_irq_req = !irq_sync_ff;
    end
    if (wr_en && paddr == port_pin_irq_pkg::ADDR_IRQ_STATUS) begin
      clr = pwdata[1:0];
    end
    set[port_pin_irq_pkg::STAT_EXT_IRQ_BIT] = nxt_ext_irq_req && !ext_irq_req_ff;
    set[port_pin_irq_pkg::STAT_PIN_CHANGE_BIT] = |(pin_sync ^ pin_prev);
    // A set in the cycle of its clear wins, so no event is lost
    nxt_irq_status = (irq_status_ff & ~clr) | set;
    nxt_irq = |(nxt_irq_status & nxt_irq_mask);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_status_ff <= port_pin_irq_pkg::RST_IRQ_STATUS;
      edge_latch_ff <= 1'b0;
      ext_irq_req_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      irq_status_ff <= nxt_irq_status;
      edge_latch_ff <= nxt_edge_latch;
      ext_irq_req_ff <= nxt_ext_irq_req;
      irq_ff <= nxt_irq;
    end
  end

  // ****************************************************
  // Port T pins, one slice per pin
  // ****************************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    logic meta_ff, sync_ff, prev_ff;
    logic drv_free, oc_ok;
    logic oe_ff, nxt_oe;
    logic out_ff, nxt_out;
    logic cap_in_ff, nxt_cap_in;
    logic cap_valid_ff, nxt_cap_valid;

    // Two flops against metastability, a third for change detection
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        meta_ff <= 1'b0;
        sync_ff <= 1'b0;
        prev_ff <= 1'b0;
      end else begin
        meta_ff <= port_t_in[i];
        sync_ff <= meta_ff;
        prev_ff <= sync_ff;
      end
    end
    assign pin_sync[i] = sync_ff;
    assign pin_prev[i] = prev_ff;

    assign drv_free = !periph.high_side_driver_routed[i] && !periph.low_side_driver_routed[i];
    assign oc_ok = periph.timer_oc_en[i] && drv_free;

    always_comb begin
      // General-purpose default, stored bit on output
      nxt_oe = port_t_dir_ff[i];
      nxt_out = port_t_data_ff[i];
      if (periph.pwm_en[i] && drv_free) begin
        nxt_oe = 1'b1;
        nxt_out = periph.pwm_out[i];
      end
      if (oc_ok) begin
        nxt_oe = 1'b1;
        nxt_out = periph.timer_oc_out[i];
      end
      if (i >= 2) begin
        if (periph.spi_en[i]) begin
          nxt_oe = periph.spi_oe[i];
          nxt_out = periph.spi_out[i];
        end else if (periph.lin_en[i]) begin
          nxt_oe = periph.lin_oe[i];
          nxt_out = periph.lin_out[i];
        end
      end else if (periph.uart0_en[i]) begin
        nxt_oe = periph.uart0_oe[i];
        nxt_out = periph.uart0_out[i];
      end else if (i == 1 && periph.lin_direct_drive_en[i]) begin
        nxt_oe = 1'b1;
        nxt_out = periph.lin_direct_drive_out[i];
      end
      nxt_cap_in = sync_ff;
      // Capture is withheld while the LIN receiver owns the pin
      nxt_cap_valid = !periph.lin_receive_out_used[i];
    end

    always_ff @(posedge clock) begin
      if (!rst_n) begin
        oe_ff <= 1'b0;
        out_ff <= 1'b0;
        cap_in_ff <= 1'b0;
        cap_valid_ff <= 1'b0;
      end else begin
        oe_ff <= nxt_oe;
        out_ff <= nxt_out;
        cap_in_ff <= nxt_cap_in;
        cap_valid_ff <= nxt_cap_valid;
      end
    end
    assign port_t_drive.oe[i] = oe_ff;
    assign port_t_drive.out[i] = out_ff;
    assign timer_capture_in[i] = cap_in_ff;
    assign timer_capture_valid[i] = cap_valid_ff;
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port_t_data_ff <= port_pin_irq_pkg::RST_PORT_T_DATA;
      port_t_dir_ff <= port_pin_irq_pkg::RST_PORT_T_DIR;
      misc_config_ff <= port_pin_irq_pkg::RST_MISC_CONFIG;
      edge_only_select_ff <= 1'b0;
      edge_locked_ff <= 1'b0;
      ext_irq_connect_ff <= 1'b0;
      factory_reserved_ff <= port_pin_irq_pkg::RST_FACTORY_RESERVED;
      irq_mask_ff <= port_pin_irq_pkg::RST_IRQ_MASK;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      port_t_data_ff <= nxt_port_t_data;
      port_t_dir_ff <= nxt_port_t_dir;
      misc_config_ff <= nxt_misc_config;
      edge_only_select_ff <= nxt_edge_only_select;
      edge_locked_ff <= nxt_edge_locked;
      ext_irq_connect_ff <= nxt_ext_irq_connect;
      factory_reserved_ff <= nxt_factory_reserved;
      irq_mask_ff <= nxt_irq_mask;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign overcurrent_detect_enable =
    misc_config_ff[port_pin_irq_pkg::OVERCURRENT_DETECT_ENABLE_BIT];
  assign ext_irq_req = ext_irq_req_ff;
  assign irq = irq_ff;
endmodule
`default_nettype wire

// ### testbench/port_pin_irq_checker.sv
// Concurrent checks on the port pin and interrupt control block
`timescale 1ns/1ps
`default_nettype none
module irq_pin_checker #(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic special_mode,
  input wire logic ext_irq_pin,
  input wire logic ext_irq_service,
  input wire port_pin_irq_pkg::port_t_periph_s periph,
  input wire port_pin_irq_pkg::port_t_drive_s port_t_drive,
  input wire logic [3:0] timer_capture_valid,
  input wire logic overcurrent_detect_enable,
  input wire logic ext_irq_req
);
  // ****************************************************
  // Shadow of control bits, taken at each completed write
  // ****************************************************
  logic wr, e_md, l_md, edge_ff, conn_ff, lock_ff, ocd_ff;
  assign wr = psel && penable && pready && pwrite;
  assign e_md = edge_ff && conn_ff && !psel;
  assign l_md = !edge_ff && conn_ff && !psel;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      {edge_ff, conn_ff, lock_ff, ocd_ff} <= 4'h0;
    end else if (wr && paddr == port_pin_irq_pkg::ADDR_EXT_IRQ_CONTROL) begin
      conn_ff <= pwdata[6];
      if (!lock_ff || special_mode) begin
        edge_ff <= pwdata[7];
      end
      lock_ff <= lock_ff || !special_mode;
    end else if (wr && paddr == port_pin_irq_pkg::ADDR_MISC_CONFIG) begin
      ocd_ff <= pwdata[7];
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access start");
  a_err_unmapped: assert property (pready |-> pslverr == !(paddr inside
    {[12'h240:12'h260]} && paddr[1:0] == 2'h0 && paddr != 12'h24C))
    else $error("error response wrong for address");
  a_ocd_follows: assert property (!psel |-> overcurrent_detect_enable == ocd_ff)
    else $error("detector enable differs from written bit");
  a_level_req: assert property ((l_md && !ext_irq_pin) [*5] |-> ext_irq_req)
    else $error("low level not recognised");
  a_unconn_quiet: assert property ((!conn_ff && !psel) [*4] |-> !ext_irq_req)
    else $error("request while pin disconnected");
  a_edge_held: assert property (e_md && ext_irq_req && !ext_irq_service &&
    !$past(ext_irq_service) |=> ext_irq_req)
    else $error("edge latch lost without service");
  a_edge_only: assert property ((e_md && !ext_irq_pin) [*5] ##1
    (e_md && !ext_irq_pin && ext_irq_service) ##1 (e_md && !ext_irq_pin) [*3]
    |-> !ext_irq_req)
    else $error("low level seen in edge mode");
  a_uart_wins: assert property ($past(rst_n && periph.uart0_en[0])
    |-> port_t_drive.oe[0] == $past(periph.uart0_oe[0]))
    else $error("uart0 not owning bit 0");
  a_spi_wins: assert property ($past(rst_n && periph.spi_en[3])
    |-> port_t_drive.oe[3] == $past(periph.spi_oe[3]))
    else $error("spi not owning bit 3");
  a_capture_gate: assert property ($past(rst_n)
    |-> (timer_capture_valid & $past(periph.lin_receive_out_used)) == 4'h0)
    else $error("capture valid on lin receive pin");
  c_err: cover property (pready && pslverr);
  c_level: cover property (l_md && ext_irq_req);
  c_service: cover property (e_md && ext_irq_req ##1 ext_irq_service);
endmodule
bind port_pin_irq_control irq_pin_checker #(.WIDTH(WIDTH)) i_chk (.clock(clock),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .special_mode(special_mode),
  .ext_irq_pin(ext_irq_pin), .ext_irq_service(ext_irq_service), .periph(periph),
  .port_t_drive(port_t_drive), .timer_capture_valid(timer_capture_valid),
  .overcurrent_detect_enable(overcurrent_detect_enable), .ext_irq_req(ext_irq_req));
`default_nettype wire

// ### testbench/port_t_pin_model.sv
// Port T pads: the block's drive where enabled, else the board level
`timescale 1ns/1ps
`default_nettype none
module port_t_pin_model (
  input wire port_pin_irq_pkg::port_t_drive_s drive,
  input wire logic [3:0] ext_level,
  output logic [3:0] pad
);
  assign pad = (drive.oe & drive.out) | (~drive.oe & ext_level);
endmodule
`default_nettype wire

// ### testbench/tb_port_pin_irq_control.sv
// Self-checking bench for the port pin and interrupt control block
`timescale 1ns/1ps
`default_nettype none
module tb_port_pin_irq_control;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic special_mode = 1'b0;
  logic ext_irq_pin = 1'b1;
  logic ext_irq_service = 1'b0;
  logic [3:0] ext_lvl = 4'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, err, ocd, req, irq;
  logic [3:0] pad, cap_ok, cap_in, dir, dat, pins;
  logic [95:0] rnd;
  logic [11:0] regs [5] = '{12'h248, 12'h250, 12'h254, 12'h258, 12'h260};
  int seed = 83986;
  int fails = 0;
  int comparisons = 0;
  port_pin_irq_pkg::port_t_periph_s periph = '0;
  port_pin_irq_pkg::port_t_drive_s port_t_drive, ed;
  always #20 clock = ~clock;
  port_pin_irq_control i_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .special_mode(special_mode),
    .ext_irq_pin(ext_irq_pin), .ext_irq_service(ext_irq_service), .port_t_in(pad),
    .periph(periph), .port_t_drive(port_t_drive), .timer_capture_in(cap_in),
    .timer_capture_valid(cap_ok), .overcurrent_detect_enable(ocd), .ext_irq_req(req),
    .irq(irq));
  port_t_pin_model i_pins (.drive(port_t_drive), .ext_level(ext_lvl), .pad(pad));
  // ****************************************************
  // Bus cycles, comparison and expected pin drive
  // ****************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, r);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask
  function automatic port_pin_irq_pkg::port_t_drive_s exp_drive(
    port_pin_irq_pkg::port_t_periph_s p, logic [3:0] dr, logic [3:0] da);
    port_pin_irq_pkg::port_t_drive_s d;
    logic [3:0] rt;
    rt = p.high_side_driver_routed | p.low_side_driver_routed;
    d.oe = dr;
    d.out = da;
    for (int i = 0; i < 4; i++) begin
      if (p.pwm_en[i] && !rt[i]) {d.oe[i], d.out[i]} = {1'b1, p.pwm_out[i]};
      if (p.timer_oc_en[i] && !rt[i]) {d.oe[i], d.out[i]} = {1'b1, p.timer_oc_out[i]};
      if (i > 1 && p.lin_en[i]) {d.oe[i], d.out[i]} = {p.lin_oe[i], p.lin_out[i]};
      if (i == 1 && p.lin_direct_drive_en[i]) begin
        {d.oe[i], d.out[i]} = {1'b1, p.lin_direct_drive_out[i]};
      end
      if (i > 1 && p.spi_en[i]) {d.oe[i], d.out[i]} = {p.spi_oe[i], p.spi_out[i]};
      if (i < 2 && p.uart0_en[i]) {d.oe[i], d.out[i]} = {p.uart0_oe[i], p.uart0_out[i]};
    end
    return d;
  endfunction
  task automatic print_verdict;
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    wait_n(10);
    rst_n <= 1'b1;
    foreach (regs[i]) rd("reset value", regs[i], 32'h0);
    apb(1'b0, 12'h24C, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, r);
    for (int v = 1; v >= 0; v--) begin
      apb(1'b1, 12'h250, 32'(v) << 7);
      wait_n(1);
      chk("detector enable", 32'(v), 32'(ocd));
    end
    apb(1'b1, 12'h258, 32'h5A);
    rd("factory normal", 12'h258, 32'h0);
    special_mode <= 1'b1;
    apb(1'b1, 12'h258, 32'h5A);
    rd("factory special", 12'h258, 32'h5A);
    special_mode <= 1'b0;
    apb(1'b1, 12'h254, 32'h80);
    apb(1'b1, 12'h254, 32'h40);
    rd("edge select lock", 12'h254, 32'hC0);
    special_mode <= 1'b1;
    apb(1'b1, 12'h254, 32'h40);
    rd("edge select special", 12'h254, 32'h40);
    ext_irq_pin <= 1'b0;
    wait_n(6);
    chk("level request", 32'h1, 32'(req));
    ext_irq_pin <= 1'b1;
    wait_n(6);
    chk("level release", 32'h0, 32'(req));
    apb(1'b1, 12'h254, 32'h00);
    ext_irq_pin <= 1'b0;
    wait_n(6);
    chk("disconnected", 32'h0, 32'(req));
    ext_irq_pin <= 1'b1;
    apb(1'b1, 12'h254, 32'hC0);
    ext_irq_pin <= 1'b0;
    wait_n(3);
    ext_irq_pin <= 1'b1;
    wait_n(6);
    chk("edge latched", 32'h1, 32'(req));
    ext_irq_pin <= 1'b0;
    wait_n(8);
    ext_irq_service <= 1'b1;
    wait_n(1);
    ext_irq_service <= 1'b0;
    wait_n(4);
    chk("edge only", 32'h0, 32'(req));
    ext_irq_pin <= 1'b1;
    special_mode <= 1'b0;
    apb(1'b1, 12'h254, 32'h40);
    rd("edge lock kept", 12'h254, 32'hC0);
    apb(1'b1, 12'h260, 32'h1);
    wait_n(2);
    chk("irq unmasked", 32'h1, 32'(irq));
    apb(1'b1, 12'h260, 32'h0);
    wait_n(2);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, 12'h260, 32'h1);
    rd("irq status", 12'h25C, 32'h1);
    apb(1'b1, 12'h25C, 32'h1);
    wait_n(2);
    chk("irq cleared", 32'h0, 32'(irq));
    rd("status cleared", 12'h25C, 32'h0);
    for (int k = 0; k < 40; k++) begin
      dir = 4'($random(seed));
      dat = 4'($random(seed));
      rnd = {$random(seed), $random(seed), $random(seed)};
      ext_lvl <= 4'($random(seed));
      apb(1'b1, 12'h248, {28'h0, dir});
      apb(1'b1, 12'h240, {28'h0, dat});
      periph <= k[0] ? rnd[71:0] : 72'h0;
      wait_n(4);
      ed = exp_drive(periph, dir, dat);
      pins = (ed.oe & ed.out) | (~ed.oe & ext_lvl);
      chk("drive enable", {28'h0, ed.oe}, {28'h0, port_t_drive.oe});
      chk("drive out", {28'h0, ed.oe & ed.out}, {28'h0, port_t_drive.oe & port_t_drive.out});
      chk("capture valid", {28'h0, ~periph.lin_receive_out_used}, {28'h0, cap_ok});
      rd("data read", 12'h240, {28'h0, (dir & dat) | (~dir & pins)});
      rd("input read", 12'h244, {28'h0, pins});
      chk("capture in", {28'h0, pins}, {28'h0, cap_in});
    end
    print_verdict();
  end
  initial begin
    wait_n(20000);
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
